// *** common/sdf_pkg.sv ***
package sdf_pkg;
  // modulator clock is the system clock divided by this
  localparam int unsigned MOD_DIV = 6;
  localparam logic [2:0] MOD_DIV_LAST = 3'h5;
  localparam logic [2:0] MOD_CLK_HIGH = 3'h3;
  // oversampling ratio and its counter terminal value
  localparam int unsigned OSR = 64;
  localparam logic [5:0] OSR_LAST = 6'h3f;
  localparam int unsigned STAGES = 5;
  // conversions needed before the output is settled
  localparam logic [2:0] SETTLE_CONV = 3'h5;
  // last count of the ready line low time; the line stays low one system clock longer than this
  localparam logic [2:0] DRDY_LOW_LAST = 3'h5;
  localparam int unsigned ACC_W = 32;
  localparam int unsigned RES_W = 24;
  localparam logic [23:0] RES_POS_FULL = 24'h7fffff;
  localparam logic signed [31:0] ACC_POS_LIMIT = 32'sh40000000;
  localparam logic [23:0] RES_RESET = 24'h000000;

  typedef struct packed {
    logic settled;
    logic [RES_W-1:0] data;
  } sdf_result_t;

  localparam int unsigned RESULT_BITS = $bits(sdf_result_t);
endpackage : sdf_pkg

// *** verilog/sdf_buffer.sv ***
`timescale 1ns/1ps
`default_nettype none
// two-entry fifo; full when both slots hold a word
module sdf_buffer #(
  parameter int unsigned WIDTH = sdf_pkg::RESULT_BITS,
  parameter int unsigned DEPTH = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;
  wire [PW-1:0] next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
  wire [PW-1:0] next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;

  assign in_ready_o = (count != (PW + 1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= next_wr_ptr;
      if (pop) rd_ptr <= next_rd_ptr;
      count <= count + (PW + 1)'(push) - (PW + 1)'(pop);
    end
  end
endmodule : sdf_buffer
`default_nettype wire

// *** verilog/sdf_filter.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdf_filter (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_B_I,
  // modulator side
  input wire logic MOD_BIT_I,
  output logic MOD_CLK_O,
  // result side
  input wire logic RESULT_READY_I,
  output logic RESULT_VALID_O,
  output logic [23:0] RESULT_O,
  output logic DATA_OUT_READY_O,
  output logic SETTLED_O
);
  typedef logic signed [sdf_pkg::ACC_W-1:0] sdf_acc_t;

  // clamp the positive full-scale case, which would wrap to the most negative code
  function automatic logic [sdf_pkg::RES_W-1:0] sdf_scale(input sdf_acc_t v);
    if (v >= sdf_pkg::ACC_POS_LIMIT) begin
      sdf_scale = sdf_pkg::RES_POS_FULL;
    end else begin
      sdf_scale = v[30:7];
    end
  endfunction : sdf_scale

  logic [2:0] div_cnt;
  logic [5:0] dec_cnt;
  logic [2:0] conv_cnt;
  logic [2:0] low_cnt;
  logic low_act;
  sdf_acc_t integ [sdf_pkg::STAGES];
  sdf_acc_t dly [sdf_pkg::STAGES];
  sdf_acc_t comb [sdf_pkg::STAGES];
  logic pend_valid;
  sdf_pkg::sdf_result_t pend;
  logic buf_in_ready;
  logic buf_out_valid;
  sdf_pkg::sdf_result_t buf_out;

  // the modulator clock halts while a finished word has nowhere to go, so nothing is dropped
  wire stall = pend_valid & ~buf_in_ready;
  wire div_wrap = (div_cnt == sdf_pkg::MOD_DIV_LAST);
  wire tick = div_wrap & ~stall;
  wire dump = tick & (dec_cnt == sdf_pkg::OSR_LAST);
  wire [2:0] next_div_cnt = div_wrap ? 3'h0 : div_cnt + 3'h1;
  // high on counts one to three, so the first high phase after reset is already full length
  wire next_mod_clk = (next_div_cnt != 3'h0) & (next_div_cnt <= sdf_pkg::MOD_CLK_HIGH);
  wire sdf_acc_t mod_val = MOD_BIT_I ? sdf_acc_t'(1) : sdf_acc_t'(-1);
  // a new word waits until the previous ready pulse has run its full length
  wire drdy_idle = ~low_act;
  wire load = buf_out_valid & (~RESULT_VALID_O | RESULT_READY_I) & drdy_idle;
  wire settled_now = (conv_cnt == sdf_pkg::SETTLE_CONV);
  wire settled_next = (conv_cnt >= sdf_pkg::SETTLE_CONV - 3'h1);
  wire low_done = (low_cnt == 3'h0);

  // differentiators at the decimated rate; wraparound arithmetic is exact for this structure
  always_comb begin
    comb[0] = integ[sdf_pkg::STAGES-1] - dly[0];
    for (int i = 1; i < sdf_pkg::STAGES; i++) begin
      comb[i] = comb[i-1] - dly[i];
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      div_cnt <= 3'h0;
    end else if (!stall) begin
      div_cnt <= next_div_cnt;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      MOD_CLK_O <= 1'b0;
    end else if (!stall) begin
      MOD_CLK_O <= next_mod_clk;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      dec_cnt <= 6'h00;
    end else if (tick) begin
      dec_cnt <= dec_cnt + 6'h01;
    end
  end

  // integrators at the modulator rate; each stage adds the last value of the one before
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      for (int i = 0; i < sdf_pkg::STAGES; i++) begin
        integ[i] <= '0;
      end
    end else if (tick) begin
      integ[0] <= integ[0] + mod_val;
      for (int i = 1; i < sdf_pkg::STAGES; i++) begin
        integ[i] <= integ[i] + integ[i-1];
      end
    end
  end

  // differentiator delays, loaded once per conversion
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      for (int i = 0; i < sdf_pkg::STAGES; i++) begin
        dly[i] <= '0;
      end
    end else if (dump) begin
      dly[0] <= integ[sdf_pkg::STAGES-1];
      for (int i = 1; i < sdf_pkg::STAGES; i++) begin
        dly[i] <= comb[i-1];
      end
    end
  end

  // conversion count; the first words out of reset still carry startup history
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      conv_cnt <= 3'h0;
    end else if (dump && !settled_now) begin
      conv_cnt <= conv_cnt + 3'h1;
    end
  end

  // a dump wins over a hand-over; the buffer takes the old word in that same cycle
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pend_valid <= 1'b0;
    end else if (dump) begin
      pend_valid <= 1'b1;
    end else if (buf_in_ready) begin
      pend_valid <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pend <= '0;
    end else if (dump) begin
      pend.data <= sdf_scale(comb[sdf_pkg::STAGES-1]);
      pend.settled <= settled_next;
    end
  end

  sdf_buffer #(
    .WIDTH(sdf_pkg::RESULT_BITS),
    .DEPTH(2)
  ) sdf_buffer_inst (
    .clk_i(CLK_I),
    .rst_b_i(RST_B_I),
    .in_valid_i(pend_valid),
    .in_ready_o(buf_in_ready),
    .in_data_i(pend),
    .out_valid_o(buf_out_valid),
    .out_ready_i(load),
    .out_data_o(buf_out)
  );

  // result_output_register; a word stays until the next load
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      RESULT_O <= sdf_pkg::RES_RESET;
    end else if (load) begin
      RESULT_O <= buf_out.data;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      SETTLED_O <= 1'b0;
    end else if (load) begin
      SETTLED_O <= buf_out.settled;
    end
  end

  // a load wins over a read in the same cycle, so the fresh word stays flagged
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      RESULT_VALID_O <= 1'b0;
    end else if (load) begin
      RESULT_VALID_O <= 1'b1;
    end else if (RESULT_READY_I) begin
      RESULT_VALID_O <= 1'b0;
    end
  end

  // ready pulse lasts six system clocks, from the edge after the register write
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      low_act <= 1'b0;
    end else if (load) begin
      low_act <= 1'b1;
    end else if (low_done) begin
      low_act <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      low_cnt <= 3'h0;
    end else if (load) begin
      low_cnt <= sdf_pkg::DRDY_LOW_LAST;
    end else if (!low_done) begin
      low_cnt <= low_cnt - 3'h1;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      DATA_OUT_READY_O <= 1'b1;
    end else begin
      DATA_OUT_READY_O <= drdy_idle;
    end
  end
endmodule : sdf_filter
`default_nettype wire

// *** tb/sdf_filter_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdf_filter_props (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_B_I,
  // watched ports
  input wire logic MOD_CLK_O,
  input wire logic RESULT_READY_I,
  input wire logic RESULT_VALID_O,
  input wire logic [23:0] RESULT_O,
  input wire logic DATA_OUT_READY_O,
  input wire logic SETTLED_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);
  AST_MOD_HIGH: assert property ($rose(MOD_CLK_O) |-> MOD_CLK_O[*3])
    else $error("modulator clock high phase short");
  AST_MOD_LOW: assert property ($fell(MOD_CLK_O) |-> (!MOD_CLK_O)[*3])
    else $error("modulator clock low phase short");
  // an empty register means the path has room, so the divider must run
  AST_MOD_RUNS: assert property (!RESULT_VALID_O |-> ##[1:4] $changed(MOD_CLK_O))
    else $error("modulator clock stuck with room in path");
  AST_DRDY_LOW: assert property ($fell(DATA_OUT_READY_O) |->
    (!DATA_OUT_READY_O)[*6] ##[1:400] DATA_OUT_READY_O)
    else $error("ready line low time wrong");
  AST_DRDY_AFTER_LOAD: assert property ($rose(RESULT_VALID_O) |=> !DATA_OUT_READY_O)
    else $error("ready line not low after load");
  AST_VALID_HOLD: assert property (RESULT_VALID_O && !RESULT_READY_I |=>
    RESULT_VALID_O && $stable(RESULT_O))
    else $error("unread word lost or changed");
  AST_SETTLED_STICKY: assert property (SETTLED_O |=> SETTLED_O)
    else $error("settled flag dropped");
  AST_SETTLED_LOAD: assert property ($changed(SETTLED_O) |-> RESULT_VALID_O)
    else $error("settled flag moved without a word");
  COV_LOAD: cover property ($rose(RESULT_VALID_O));
  COV_STALL: cover property ((RESULT_VALID_O && !RESULT_READY_I)[*8]);
  COV_SETTLED: cover property ($rose(SETTLED_O));
endmodule : sdf_filter_props
bind sdf_filter sdf_filter_props sdf_filter_props_inst (.CLK_I(CLK_I), .RST_B_I(RST_B_I),
  .MOD_CLK_O(MOD_CLK_O), .RESULT_READY_I(RESULT_READY_I), .RESULT_VALID_O(RESULT_VALID_O),
  .RESULT_O(RESULT_O), .DATA_OUT_READY_O(DATA_OUT_READY_O), .SETTLED_O(SETTLED_O));
`default_nettype wire

// *** tb/sdf_mod_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdf_mod_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // stream control
  input wire logic mod_clk_i,
  input wire logic [1:0] mode_i,
  output logic mod_bit_o
);
  logic last_clk;
  // new bit just after the modulator clock rises, far from the sampling edge
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      last_clk <= 1'b0;
      mod_bit_o <= 1'b0;
    end else begin
      last_clk <= mod_clk_i;
      if (mod_clk_i && !last_clk) begin
        mod_bit_o <= (mode_i == 2'h2) ? !mod_bit_o : (mode_i == 2'h3) ? 1'($urandom) : mode_i[0];
      end
    end
  end
endmodule : sdf_mod_model
`default_nettype wire

// *** tb/sdf_filter_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdf_filter_tb_top;
  logic clk, rst_b, mod_bit, mod_clk, rdy, vld, drdy, settled, prev_drdy;
  logic [23:0] res;
  logic [1:0] mode, rdy_mode;
  logic [24:0] words[$];
  int error_cnt, samples_checked, cyc, last_fall, gap;

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  sdf_filter sdf_filter_inst (.CLK_I(clk), .RST_B_I(rst_b), .MOD_BIT_I(mod_bit),
    .MOD_CLK_O(mod_clk), .RESULT_READY_I(rdy), .RESULT_VALID_O(vld), .RESULT_O(res),
    .DATA_OUT_READY_O(drdy), .SETTLED_O(settled));
  sdf_mod_model sdf_mod_model_inst (.clk_i(clk), .rst_b_i(rst_b), .mod_clk_i(mod_clk),
    .mode_i(mode), .mod_bit_o(mod_bit));

  always @(posedge clk) begin
    cyc <= cyc + 1;
    rdy <= (rdy_mode == 2'h2) ? 1'($urandom) : rdy_mode[0];
    prev_drdy <= drdy;
    if (vld && rdy) words.push_back({settled, res});
    if (prev_drdy && !drdy) begin
      gap <= cyc - last_fall;
      last_fall <= cyc;
    end
  end

  function automatic logic [24:0] full_word(logic [1:0] m);
    return {1'b1, (m == 2'h1) ? 24'h7fffff : (m == 2'h0) ? 24'h800000 : 24'h000000};
  endfunction : full_word

  task automatic chk(string n, logic [24:0] e, logic [24:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic take(output logic [24:0] w);
    int t;
    t = 0;
    while (words.size() == 0 && t < 2000) begin
      @(posedge clk);
      t++;
    end
    w = (words.size() != 0) ? words.pop_front() : 25'bx;
  endtask : take

  task end_of_test;
    if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  initial begin
    logic [24:0] w;
    logic [1:0] steps[3];
    int lf;
    steps = '{2'h0, 2'h2, 2'h1};
    {error_cnt, samples_checked, cyc, last_fall, gap} = '0;
    {rst_b, rdy} = 2'b00;
    {prev_drdy, mode, rdy_mode} = 5'b10101;
    void'($urandom(32'h51ac6f92));
    repeat (16) @(posedge clk);
    chk("idle", {1'b1, 24'h0}, {drdy, res});
    rst_b <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      take(w);
      chk("settled", {24'h0, i > 3}, {24'h0, w[24]});
      if (i > 3) chk("full_scale", full_word(2'h1), w);
    end
    chk("word_gap", 25'(384), 25'(gap));
    foreach (steps[i]) begin
      repeat ($urandom_range(383)) @(posedge clk);
      mode <= steps[i];
      words.delete();
      repeat (6) take(w);
      take(w);
      chk("step", full_word(steps[i]), w);
    end
    // a long stall must freeze conversion rather than drop words
    rdy_mode <= 2'h0;
    repeat (3000) @(posedge clk);
    lf = last_fall;
    repeat (400) @(posedge clk);
    chk("stall", 25'(lf), 25'(last_fall));
    rdy_mode <= 2'h1;
    repeat (40) @(posedge clk);
    chk("drain", 25'(4), 25'(words.size()));
    repeat (4) begin
      take(w);
      chk("drained", full_word(2'h1), w);
    end
    mode <= 2'h3;
    rdy_mode <= 2'h2;
    repeat (4000) @(posedge clk);
    chk("rand_words", 25'(1), 25'(words.size() > 5));
    while (words.size() != 0) begin
      take(w);
      chk("rand_settled", 25'(1), 25'(w[24]));
    end
    end_of_test();
  end

  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end
endmodule : sdf_filter_tb_top
`default_nettype wire
